/* tph_pkg.sv */
// Package for the transmit packet handler: constants, modes, states and carriers.
package tph_pkg;
   localparam logic [1:0] LEN_FIXED      = 2'h0;
   localparam logic [1:0] LEN_VARIABLE   = 2'h1;
   localparam logic [1:0] LEN_INFINITE   = 2'h2;
   localparam logic [5:0] PIN_FIFO_THR   = 6'h02;
   localparam logic [5:0] PIN_FIFO_FULL  = 6'h03;
   localparam logic [5:0] PIN_SYNC_PKT   = 6'h06;
   localparam logic [6:0] FIFO_DEPTH     = 7'h40;
   localparam logic [6:0] FIFO_THRESHOLD = 7'h3D;
   localparam logic [7:0] PREAMBLE_BYTE  = 8'hAA;
   localparam logic [8:0] PN9_SEED       = 9'h1FF;
   localparam logic [15:0] CRC_SEED      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'h8005;
   localparam logic [2:0] MOD_FSK        = 3'h0;
   localparam logic [2:0] MOD_GFSK       = 3'h1;
   localparam logic [2:0] MOD_OOK        = 3'h3;
   localparam logic [2:0] MOD_MSK        = 3'h7;
   localparam logic [2:0] BIT_LAST       = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_PREAMBLE = 3'b001,
      ST_SYNC     = 3'b010,
      ST_PAYLOAD  = 3'b011,
      ST_CRC      = 3'b100,
      ST_UNDERRUN = 3'b101
   } tph_state_t;

   typedef struct packed {
      logic [1:0]  length_config;
      logic        crc_enable;
      logic        whitening_enable;
      logic        error_correction_enable;
      logic        manchester_enable;
      logic        sync_four_bytes;
      logic [2:0]  modulation_format;
      logic [3:0]  preamble_bytes;
      logic [7:0]  packet_length_value;
      logic [15:0] sync_word;
      logic [1:0]  after_transmit_state_select;
      logic [5:0]  output_pin_config;
   } tph_cfg_t;

   typedef struct packed {
      logic       bit_value;
      logic       is_data;
      logic       pa_enable;
      logic       deviation_positive;
   } tph_sym_t;
endpackage

/* tph_tx_packet_handler.sv */
// Transmit packet handler: framing, CRC, whitening, status pin and symbol mapping.
`timescale 1ns/1ps
module tph_tx_packet_handler (
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   input  wire tph_pkg::tph_cfg_t i_cfg,
   input  wire logic            i_tx_start,
   input  wire logic            i_flush_transmit_fifo_strobe,
   input  wire logic            i_fifo_valid,
   input  wire logic [7:0]      i_fifo_data,
   input  wire logic [6:0]      i_fifo_count,
   input  wire logic            i_bit_tick,
   output logic                 o_fifo_pop,
   output tph_pkg::tph_sym_t    o_symbol,
   output logic                 o_fec_bit,
   output logic                 o_busy,
   output logic                 o_transmit_underflow_state,
   output logic                 o_packet_done,
   output logic [1:0]           o_after_state,
   output logic                 o_general_output_pin_zero,
   output logic [7:0]           o_packet_status_reg,
   output logic [7:0]           o_transmit_fill_count_reg,
   output logic [7:0]           o_chip_status_byte
);
   import tph_pkg::*;

   logic       rst_meta;
   logic       rst_sync_n;
   tph_state_t state;
   logic [7:0] shreg;
   logic [2:0] bit_idx;
   logic [3:0] unit_cnt;
   logic [7:0] byte_cnt;
   logic [7:0] var_len;
   logic       len_seen;
   logic [8:0] pn9;
   logic [15:0] crc;
   logic       byte_end;
   logic       last_byte;
   logic       pin_sync_pkt;
   logic       cur_bit;
   logic       wbit;
   logic       crc_fb;
   logic       fec_on;
   logic [15:0] next_crc;
   logic       pin_level;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   assign byte_end = i_bit_tick && (bit_idx == BIT_LAST);
   assign cur_bit  = shreg[7];
   // Manchester is not implemented; manchester_enable is ignored and error_correction_enable alone turns the coder on.
   assign fec_on   = i_cfg.error_correction_enable;

   // The terminating compare uses the length in force now, so after a host switch from
   // infinite to fixed mode mid-packet, the packet ends when the wrapping byte count next matches.
   always_comb begin
      case (i_cfg.length_config)
         LEN_FIXED:    last_byte = (byte_cnt + 8'h01) == i_cfg.packet_length_value;
         LEN_VARIABLE: last_byte = len_seen && ((byte_cnt + 8'h01) == (var_len + 8'h01));
         default:      last_byte = 1'b0;
      endcase
   end

   // Frame sequencer.
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (i_tx_start) begin
                  state <= ST_PREAMBLE;
               end
            end
            ST_PREAMBLE: begin
               // Preamble repeats until the FIFO holds data.
               if (byte_end && unit_cnt == 4'h0 && i_fifo_valid) begin
                  state <= ST_SYNC;
               end
            end
            ST_SYNC: begin
               if (byte_end && unit_cnt == 4'h0) begin
                  state <= i_fifo_valid ? ST_PAYLOAD : ST_UNDERRUN;
               end
            end
            ST_PAYLOAD: begin
               if (byte_end) begin
                  if (last_byte) begin
                     state <= i_cfg.crc_enable ? ST_CRC : ST_IDLE;
                  end else if (!i_fifo_valid) begin
                     state <= ST_UNDERRUN;
                  end
               end
            end
            ST_CRC: begin
               if (byte_end && unit_cnt == 4'h0) begin
                  state <= ST_IDLE;
               end
            end
            ST_UNDERRUN: begin
               // FIFO writes alone never restart transmission.
               if (i_flush_transmit_fifo_strobe) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Shift register, bit index and per-section byte countdown.
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shreg    <= 8'h00;
         bit_idx  <= 3'h0;
         unit_cnt <= 4'h0;
      end else if (state == ST_IDLE && i_tx_start) begin
         shreg    <= PREAMBLE_BYTE;
         bit_idx  <= 3'h0;
         unit_cnt <= i_cfg.preamble_bytes - 4'h1;
      end else if (i_bit_tick && state != ST_IDLE && state != ST_UNDERRUN) begin
         bit_idx <= bit_idx + 3'h1;
         shreg   <= {shreg[6:0], 1'b0};
         if (byte_end) begin
            if (unit_cnt != 4'h0) begin
               unit_cnt <= unit_cnt - 4'h1;
               case (state)
                  ST_SYNC: shreg <= unit_cnt[0] ?
                                    i_cfg.sync_word[7:0] : i_cfg.sync_word[15:8];
                  ST_CRC:  shreg <= crc[7:0];
                  default: shreg <= PREAMBLE_BYTE;
               endcase
            end else if (state == ST_PREAMBLE && i_fifo_valid) begin
               shreg    <= i_cfg.sync_word[15:8];
               unit_cnt <= i_cfg.sync_four_bytes ? 4'h3 : 4'h1;
            end else if (state == ST_PREAMBLE) begin
               shreg <= PREAMBLE_BYTE;
            end else if (state == ST_SYNC || (state == ST_PAYLOAD && !last_byte)) begin
               shreg <= i_fifo_data;
            end else if (state == ST_PAYLOAD && i_cfg.crc_enable) begin
               // The high CRC byte must already include the payload bit leaving now.
               shreg    <= next_crc[15:8];
               unit_cnt <= 4'h1;
            end
         end
      end
   end

   assign o_fifo_pop = byte_end && i_fifo_valid &&
                       ((state == ST_SYNC && unit_cnt == 4'h0) ||
                        (state == ST_PAYLOAD && !last_byte));

   // Payload byte counter: clears per packet, wraps 255 to 0 naturally.
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         byte_cnt <= 8'h00;
         var_len  <= 8'h00;
         len_seen <= 1'b0;
      end else if (state == ST_IDLE) begin
         byte_cnt <= 8'h00;
         len_seen <= 1'b0;
      end else if (state == ST_SYNC && o_fifo_pop) begin
         // Taken as it leaves the FIFO; by its last bit the shifter holds only one bit of it.
         var_len  <= i_fifo_data;
         len_seen <= 1'b1;
      end else if (state == ST_PAYLOAD && byte_end) begin
         byte_cnt <= byte_cnt + 8'h01;
      end
   end

   // CRC over every payload bit; PN9 restarts each packet.
   assign crc_fb   = crc[15] ^ cur_bit;
   assign next_crc = {crc[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000);
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         crc <= CRC_SEED;
         pn9 <= PN9_SEED;
      end else if (state == ST_IDLE) begin
         crc <= CRC_SEED;
         pn9 <= PN9_SEED;
      end else if (i_bit_tick && (state == ST_PAYLOAD || state == ST_CRC)) begin
         if (state == ST_PAYLOAD) begin
            crc <= next_crc;
         end
         pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]};
      end
   end

   // Whitening applies after the sync word and before the coder.
   assign wbit = cur_bit ^ (i_cfg.whitening_enable && (state == ST_PAYLOAD ||
                 state == ST_CRC) && pn9[8]);

   logic [2:0] conv;
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         conv      <= 3'h0;
         o_fec_bit <= 1'b0;
      end else if (i_bit_tick && fec_on && (state == ST_PAYLOAD || state == ST_CRC)) begin
         conv      <= {conv[1:0], wbit};
         o_fec_bit <= wbit ^ conv[0] ^ conv[2];
      end
   end

   // Symbol mapping per modulation format.
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_symbol <= '0;
      end else if (i_bit_tick) begin
         o_symbol.is_data <= (state == ST_PAYLOAD || state == ST_CRC);
         case (i_cfg.modulation_format)
            MOD_OOK: begin
               o_symbol.bit_value <= wbit;
               o_symbol.pa_enable <= wbit;
               o_symbol.deviation_positive <= 1'b0;
            end
            MOD_MSK: begin
               o_symbol.bit_value <= ~wbit;
               o_symbol.pa_enable <= 1'b1;
               o_symbol.deviation_positive <= ~wbit;
            end
            default: begin
               o_symbol.bit_value <= wbit;
               o_symbol.pa_enable <= 1'b1;
               o_symbol.deviation_positive <= wbit;
            end
         endcase
      end
   end

   // Status pin and readable status.
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_sync_pkt              <= 1'b0;
         o_packet_done             <= 1'b0;
         o_general_output_pin_zero <= 1'b0;
         o_packet_status_reg       <= 8'h00;
         o_transmit_fill_count_reg <= 8'h00;
         o_chip_status_byte        <= 8'h00;
      end else begin
         o_packet_done             <= 1'b0;
         // The pin and its readable copy share one stage, so a poll never sees them differ.
         o_general_output_pin_zero <= pin_level;
         o_packet_status_reg       <= {7'h00, pin_level};
         o_transmit_fill_count_reg <= {1'b0, i_fifo_count};
         o_chip_status_byte        <= {1'b0, state, i_fifo_count[3:0]};
         if (state == ST_SYNC && byte_end && unit_cnt == 4'h0) begin
            pin_sync_pkt <= 1'b1;
         end else if (state != ST_IDLE && state != ST_UNDERRUN) begin
            pin_sync_pkt <= pin_sync_pkt;
         end else begin
            pin_sync_pkt <= 1'b0;
         end
         if ((state == ST_PAYLOAD && byte_end && last_byte && !i_cfg.crc_enable) ||
             (state == ST_CRC && byte_end && unit_cnt == 4'h0)) begin
            o_packet_done <= 1'b1;
         end
      end
   end

   always_comb begin
      case (i_cfg.output_pin_config)
         PIN_FIFO_THR:  pin_level = i_fifo_count >= FIFO_THRESHOLD;
         PIN_FIFO_FULL: pin_level = i_fifo_count == FIFO_DEPTH;
         PIN_SYNC_PKT:  pin_level = pin_sync_pkt;
         default:       pin_level = 1'b0;
      endcase
   end

   assign o_transmit_underflow_state = (state == ST_UNDERRUN);
   assign o_busy                     = (state != ST_IDLE);
   assign o_after_state              = i_cfg.after_transmit_state_select;

   sequence s_sync_done;
      state == ST_SYNC && byte_end && unit_cnt == 4'h0;
   endsequence
   property p_underrun_hold;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_UNDERRUN && !i_flush_transmit_fifo_strobe |=> state == ST_UNDERRUN;
   endproperty
   a_underrun_hold: assert property (p_underrun_hold) else $error("left underflow");
   property p_flush_exit;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_UNDERRUN && i_flush_transmit_fifo_strobe |=> state == ST_IDLE;
   endproperty
   a_flush_exit: assert property (p_flush_exit) else $error("flush ignored");
   property p_ook_map;
      @(posedge i_clk) disable iff (!rst_sync_n)
         i_bit_tick && i_cfg.modulation_format == MOD_OOK |=> o_symbol.pa_enable == $past(wbit);
   endproperty
   a_ook_map: assert property (p_ook_map) else $error("OOK amplifier mismatch");
   property p_pn9_seed;
      @(posedge i_clk) disable iff (!rst_sync_n) state == ST_IDLE |=> pn9 == PN9_SEED;
   endproperty
   a_pn9_seed: assert property (p_pn9_seed) else $error("PN9 not seeded");
   property p_cnt_clear;
      @(posedge i_clk) disable iff (!rst_sync_n) state == ST_IDLE |=> byte_cnt == 8'h00;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("byte counter not cleared");
   property p_preamble_wait;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_PREAMBLE && !i_fifo_valid |=> state == ST_PREAMBLE;
   endproperty
   a_preamble_wait: assert property (p_preamble_wait) else $error("sync too early");
   property p_underflow;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_PAYLOAD && byte_end && !last_byte && !i_fifo_valid |=> state == ST_UNDERRUN;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow missed");
   property p_fixed_end;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_PAYLOAD && byte_end && last_byte && !i_cfg.crc_enable |=> state == ST_IDLE;
   endproperty
   a_fixed_end: assert property (p_fixed_end) else $error("fixed length overran");
   property p_wrap;
      @(posedge i_clk) disable iff (!rst_sync_n)
         state == ST_PAYLOAD && byte_end && byte_cnt == 8'hFF |=> byte_cnt == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("byte counter failed to wrap");
   property p_sync_pin;
      @(posedge i_clk) disable iff (!rst_sync_n) s_sync_done |=> pin_sync_pkt;
   endproperty
   a_sync_pin: assert property (p_sync_pin) else $error("sync not flagged");
endmodule

/* tph_host_model.sv */
// Host model: fills the transmit FIFO byte by byte and presents its head.
`timescale 1ns/1ps
module tph_host_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [15:0] i_supply,
   input  wire logic        i_len_first,
   input  wire logic        i_flush,
   input  wire logic        i_pop,
   output logic             o_valid,
   output logic [7:0]       o_data,
   output logic [6:0]       o_count
);
   logic [7:0]  mem [0:63];
   logic [5:0]  rd = 6'h00;
   logic [5:0]  wr = 6'h00;
   logic [15:0] sent = 16'h0000;
   logic [15:0] goal = 16'h0000;
   logic [7:0]  last = 8'h00;
   logic [7:0]  next_byte;
   logic        wr_en;
   logic        rd_en;
   initial o_count = 7'h00;
   // The length byte goes first and counts the bytes that follow it.
   assign next_byte = (i_len_first && sent == 16'h0000) ? 8'(goal - 16'h0001) : sent[7:0] ^ 8'h5C;
   assign wr_en = sent < goal && o_count < 7'h40;
   assign rd_en = i_pop && o_count != 7'h00;
   assign o_valid = o_count != 7'h00;
   // An empty FIFO shows the inverse of the last byte so stale data cannot pass.
   assign o_data = o_valid ? mem[rd] : ~last;
   always @(posedge i_clk) begin
      if (i_flush) begin
         rd <= 6'h00;
         wr <= 6'h00;
         o_count <= 7'h00;
         goal <= sent;
      end else if (i_go) begin
         sent <= 16'h0000;
         goal <= i_supply;
      end else begin
         if (wr_en) begin
            mem[wr] <= next_byte;
            wr <= wr + 6'h01;
            sent <= sent + 16'h0001;
         end
         if (rd_en) begin
            rd <= rd + 6'h01;
            last <= mem[rd];
         end
         o_count <= o_count + 7'(wr_en) - 7'(rd_en);
      end
   end
endmodule

/* tb_top.sv */
// Testbench for the transmit packet handler with a host FIFO model.
`timescale 1ns/1ps
module tb_top;
   import tph_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   tph_cfg_t cfg = '0;
   logic start = 1'b0, flush = 1'b0, go = 1'b0, len_first = 1'b0, tick = 1'b0;
   logic [15:0] supply = 16'h0000;
   logic pop, fvalid, fec, busy, under, done, pin;
   logic [7:0] fdata, pstat, fill, chip;
   logic [6:0] fcount;
   logic [1:0] after;
   tph_sym_t sym;
   logic bits[$];
   logic done_seen, pin_seen, fec_seen;
   int pops, n_mismatch = 0, cmp_count = 0;
   logic [31:0] cyc = 32'h0000_0000;
   always #20 i_clk = ~i_clk;
   tph_host_model u_host (.i_clk(i_clk), .i_go(go), .i_supply(supply), .i_len_first(len_first),
      .i_flush(flush), .i_pop(pop), .o_valid(fvalid), .o_data(fdata), .o_count(fcount));
   tph_tx_packet_handler DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_tx_start(start),
      .i_flush_transmit_fifo_strobe(flush), .i_fifo_valid(fvalid), .i_fifo_data(fdata),
      .i_fifo_count(fcount), .i_bit_tick(tick), .o_fifo_pop(pop), .o_symbol(sym),
      .o_fec_bit(fec), .o_busy(busy), .o_transmit_underflow_state(under),
      .o_packet_done(done), .o_after_state(after), .o_general_output_pin_zero(pin),
      .o_packet_status_reg(pstat), .o_transmit_fill_count_reg(fill),
      .o_chip_status_byte(chip));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One bit every four clocks keeps the long packet well inside the run limit.
   always @(posedge i_clk) begin
      cyc <= cyc + 32'h0000_0001;
      tick <= #1 (cyc[1:0] == 2'b00);
      if (cyc == 32'h0000_EA60) begin
         n_mismatch++;
         conclude();
      end
   end
   always @(posedge i_clk) begin
      pops += int'(pop);
      if (done) done_seen = 1'b1;
      if (pin) pin_seen = 1'b1;
      if (fec) fec_seen = 1'b1;
      if (tick && busy) begin
         #2;
         // MSK sends every bit inverted; undo it so the frame checks see the source data.
         bits.push_back(sym.bit_value ^ (cfg.modulation_format == MOD_MSK));
         if (cfg.modulation_format == MOD_OOK) check(sym.pa_enable, sym.bit_value);
         if (cfg.modulation_format == MOD_FSK) check(sym.deviation_positive, sym.bit_value);
      end
   end
   task automatic step;
      @(posedge i_clk);
      #1;
   endtask
   task automatic setup(input logic [1:0] lc, input logic [7:0] len, input logic crc,
                        input logic wh, input logic [2:0] md, input logic s4);
      step();
      cfg = '0;
      cfg.length_config = lc;
      cfg.packet_length_value = len;
      cfg.crc_enable = crc;
      cfg.whitening_enable = wh;
      cfg.modulation_format = md;
      cfg.sync_four_bytes = s4;
      cfg.preamble_bytes = 4'h2;
      cfg.sync_word = 16'hD391;
      cfg.after_transmit_state_select = 2'h2;
      cfg.output_pin_config = PIN_SYNC_PKT;
   endtask
   task automatic feed(input logic [15:0] n, input logic lf);
      step();
      supply = n;
      len_first = lf;
      go = 1'b1;
      step();
      go = 1'b0;
   endtask
   task automatic send(input logic [15:0] n, input logic lf);
      bits = {};
      pops = 0;
      done_seen = 1'b0;
      pin_seen = 1'b0;
      fec_seen = 1'b0;
      feed(n, lf);
      start = 1'b1;
      step();
      start = 1'b0;
   endtask
   task automatic wait_done;
      for (int k = 0; k < 20000 && !done_seen; k++) step();
   endtask
   function automatic logic [7:0] byte_at(input int k);
      for (int i = 0; i < 8; i++) byte_at[7-i] = bits[8*k+i];
   endfunction
   function automatic logic [7:0] exp_byte(input int k, input int n, input logic lf);
      return (lf && k == 0) ? 8'(n - 1) : 8'(k) ^ 8'h5C;
   endfunction
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      return c;
   endfunction
   // Preamble bytes are inferred from the frame length so a stretched preamble can be judged.
   task automatic check_frame(input int n, input logic lf, input logic ext, input logic wh);
      int s, c, p;
      logic [15:0] crc;
      s = cfg.sync_four_bytes ? 4 : 2;
      c = cfg.crc_enable ? 2 : 0;
      p = bits.size() / 8 - s - n - c;
      crc = CRC_SEED;
      check(32'(ext ? p > 2 : p == 2), 32'h0000_0001);
      for (int k = 0; k < p; k++) check(byte_at(k), PREAMBLE_BYTE);
      for (int k = 0; k < s; k++) check(byte_at(p + k), k[0] ? 8'h91 : 8'hD3);
      for (int k = 0; k < n; k++) begin
         if (!wh) check(byte_at(p + s + k), exp_byte(k, n, lf));
         crc = crc_upd(crc, exp_byte(k, n, lf));
      end
      if (wh) check(byte_at(p + s), exp_byte(0, n, lf) ^ 8'hFF);
      if (c == 2) check({byte_at(p + s + n), byte_at(p + s + n + 1)}, crc);
      check(pops, n);
      check(busy, 1'b0);
   endtask
   task automatic s_pins;
      setup(LEN_FIXED, 8'h03, 1'b0, 1'b0, MOD_FSK, 1'b0);
      feed(16'h003D, 1'b0);
      repeat (70) step();
      cfg.output_pin_config = PIN_FIFO_THR;
      step();
      check(pin, 1'b1);
      check(pstat[0], 1'b1);
      check(fill, 8'h3D);
      check(chip[3:0], 4'hD);
      cfg.output_pin_config = PIN_FIFO_FULL;
      step();
      check(pin, 1'b0);
      feed(16'h0003, 1'b0);
      repeat (6) step();
      check(pin, 1'b1);
      check(fill, 8'h40);
      flush = 1'b1;
      step();
      flush = 1'b0;
      step();
      check(pin, 1'b0);
      check(pstat[0], 1'b0);
   endtask
   task automatic s_fixed;
      setup(LEN_FIXED, 8'h03, 1'b0, 1'b0, MOD_FSK, 1'b0);
      check(pin, 1'b0);
      send(16'h0003, 1'b0);
      wait_done();
      check(done_seen, 1'b1);
      check(pin_seen, 1'b1);
      check(after, 2'h2);
      check(fec_seen, 1'b0);
      check_frame(3, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic s_var_crc;
      setup(LEN_VARIABLE, 8'h00, 1'b1, 1'b0, MOD_OOK, 1'b1);
      send(16'h0005, 1'b1);
      wait_done();
      check_frame(5, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic s_white_ext;
      setup(LEN_FIXED, 8'h02, 1'b0, 1'b1, MOD_MSK, 1'b0);
      send(16'h0002, 1'b0);
      wait_done();
      check_frame(2, 1'b0, 1'b0, 1'b1);
      setup(LEN_FIXED, 8'h02, 1'b0, 1'b0, MOD_GFSK, 1'b0);
      cfg.error_correction_enable = 1'b1;
      send(16'h0000, 1'b0);
      repeat (300) step();
      feed(16'h0002, 1'b0);
      wait_done();
      check_frame(2, 1'b0, 1'b1, 1'b0);
      check(fec_seen, 1'b1);
   endtask
   task automatic s_underflow;
      setup(LEN_FIXED, 8'h04, 1'b0, 1'b0, MOD_FSK, 1'b0);
      send(16'h0002, 1'b0);
      for (int k = 0; k < 3000 && under !== 1'b1; k++) step();
      check(under, 1'b1);
      feed(16'h0003, 1'b0);
      repeat (300) step();
      check(under, 1'b1);
      check(pops, 2);
      flush = 1'b1;
      step();
      flush = 1'b0;
      repeat (2) step();
      check(under, 1'b0);
      check(busy, 1'b0);
   endtask
   // Manchester stays off throughout, as it may not be paired with error correction.
   task automatic s_long;
      setup(LEN_INFINITE, 8'h03, 1'b1, 1'b0, MOD_FSK, 1'b0);
      send(16'h0103, 1'b0);
      for (int k = 0; k < 9000 && pops < 200; k++) step();
      cfg.length_config = LEN_FIXED;
      wait_done();
      check(done_seen, 1'b1);
      check_frame(259, 1'b0, 1'b0, 1'b0);
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      repeat (4) step();
      s_pins();
      s_fixed();
      s_var_crc();
      s_white_ext();
      s_underflow();
      s_long();
      conclude();
   end
endmodule
